// [cvg_pkg.sv]
package cvg_pkg;

  localparam logic [7:0] CVG_CH2_DELAY_ADDR = 8'h45;
  localparam logic [7:0] CVG_CH3_VOL_ADDR = 8'h48;
  localparam logic [7:0] CVG_CH3_GAIN_ADDR = 8'h49;
  localparam logic [7:0] CVG_CH3_DELAY_ADDR = 8'h4a;

  localparam logic [7:0] CVG_VOL_RST = 8'hc9;
  localparam logic [7:0] CVG_GAIN_REG_RST = 8'h80;
  localparam logic [7:0] CVG_DELAY_RST = 8'h00;

  localparam int CVG_TRIM_MSB = 7;
  localparam int CVG_TRIM_LSB = 4;
  localparam logic [7:0] CVG_VOL_MUTE = 8'h00;
  localparam logic [7:0] CVG_VOL_UNITY = 8'hc9;
  localparam logic [3:0] CVG_TRIM_UNITY = 4'h8;

  localparam int CVG_DELAY_DEPTH = 255;
  localparam int CVG_SAMPLE_W = 24;
  localparam int CVG_VOL_GAIN_W = 29;
  localparam int CVG_TRIM_GAIN_W = 17;
  localparam int CVG_VOL_FRAC = 24;
  localparam int CVG_TRIM_FRAC = 16;
  localparam int CVG_SAMPLE_LAT = 2;

  // Offset that puts unity volume on an octave boundary
  localparam logic [8:0] CVG_VOL_OFS = 9'h00f;
  localparam logic [8:0] CVG_STEPS_PER_OCT = 9'h00c;
  localparam int CVG_VOL_SHR = 10;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cvg_reg_req_t;

  typedef struct packed {
    logic valid;
    logic signed [CVG_SAMPLE_W-1:0] data;
  } cvg_sample_t;

  // Q16 gain of each half-dB step inside one 6 dB octave
  function automatic logic [16:0] cvg_step_tbl(input logic [3:0] r);
    logic [16:0] v;
    v = 17'h1_0000;
    unique case (r)
      4'h0: v = 17'h1_0000;
      4'h1: v = 17'h1_0f2c;
      4'h2: v = 17'h1_1f3d;
      4'h3: v = 17'h1_3041;
      4'h4: v = 17'h1_4248;
      4'h5: v = 17'h1_5561;
      4'h6: v = 17'h1_699c;
      4'h7: v = 17'h1_7f09;
      4'h8: v = 17'h1_95bb;
      4'h9: v = 17'h1_adc5;
      4'ha: v = 17'h1_c73d;
      4'hb: v = 17'h1_e235;
      default: v = 17'h1_0000;
    endcase
    return v;
  endfunction

  // Q24 linear gain of a volume code; octaves are taken as a plain shift,
  // which drifts by 0.02 dB per octave away from unity
  function automatic logic [CVG_VOL_GAIN_W-1:0] cvg_vol_gain(
      input logic [7:0] code);
    logic [8:0] s;
    logic [8:0] q;
    logic [8:0] r;
    logic [47:0] w;
    s = {1'b0, code} + CVG_VOL_OFS;
    q = s / CVG_STEPS_PER_OCT;
    r = s % CVG_STEPS_PER_OCT;
    w = ({31'h0000_0000, cvg_step_tbl(r[3:0])} << q) >> CVG_VOL_SHR;
    if (code == CVG_VOL_MUTE) begin
      w = 48'h0000_0000_0000;
    end
    return w[CVG_VOL_GAIN_W-1:0];
  endfunction

  // Q16 linear gain of a trim code, 0.1 dB per step
  function automatic logic [CVG_TRIM_GAIN_W-1:0] cvg_trim_gain(
      input logic [3:0] code);
    logic [16:0] v;
    v = 17'h1_0000;
    unique case (code)
      4'h0: v = 17'h0_e97a;
      4'h1: v = 17'h0_ec2e;
      4'h2: v = 17'h0_eee9;
      4'h3: v = 17'h0_f1ae;
      4'h4: v = 17'h0_f47a;
      4'h5: v = 17'h0_f74f;
      4'h6: v = 17'h0_fa2c;
      4'h7: v = 17'h0_fd12;
      4'h8: v = 17'h1_0000;
      4'h9: v = 17'h1_02f7;
      4'ha: v = 17'h1_05f7;
      4'hb: v = 17'h1_08ff;
      4'hc: v = 17'h1_0c11;
      4'hd: v = 17'h1_0f2c;
      4'he: v = 17'h1_124f;
      4'hf: v = 17'h1_157c;
    endcase
    return v;
  endfunction

endpackage

// [cvg_delay_line.sv]
`timescale 1ns/1ps
`default_nettype none
module cvg_delay_line (
  input wire logic core_clk_i, // Device clock
  input wire logic rst_n_i, // Async reset, active low
  input wire logic mod_tick_i, // One pulse per modulator clock cycle
  input wire logic pdm_bit_i, // Incoming modulator bit
  input wire logic [7:0] code_i, // Delay in modulator cycles
  output logic pdm_bit_o // Delayed bit
);
  import cvg_pkg::*;

  logic [CVG_DELAY_DEPTH-1:0] taps;
  logic [7:0] tap_idx;
  logic tap_bit;
  logic next_bit;

  assign tap_idx = code_i - 8'h01;
  assign tap_bit = taps[tap_idx];
  assign next_bit = (code_i == 8'h00) ? pdm_bit_i : tap_bit; // [R1] [R2]

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      taps <= '0;
      pdm_bit_o <= 1'b0;
    end else if (mod_tick_i) begin
      taps <= {taps[CVG_DELAY_DEPTH-2:0], pdm_bit_i};
      pdm_bit_o <= next_bit;
    end
  end

  // Bit seen at the previous tick, for checking only
  logic prev_in;
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prev_in <= 1'b0;
    end else if (mod_tick_i) begin
      prev_in <= pdm_bit_i;
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  zero_delay_pass_a: assert property ( // [R1]
    mod_tick_i && code_i == 8'h00 |=> pdm_bit_o == $past(pdm_bit_i))
    else $error("zero code did not pass the bit straight through");

  one_cycle_delay_a: assert property ( // [R2]
    mod_tick_i && code_i == 8'h01 |=> pdm_bit_o == $past(prev_in))
    else $error("code one did not delay by one modulator cycle");

  max_delay_c: cover property (mod_tick_i && code_i == 8'hff);

endmodule // cvg_delay_line
`default_nettype wire

// [cvg_chan_regs.sv]
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// [R1] Zero delay code adds no delay
// [R2] Code N delays N modulator cycles
// [R3] Channel 2 delay field bits 7:0, RW, reset zero
// [R4] Channel 3 volume at 0x48, reset 0xC9
// [R5] Volume code zero mutes the channel
// [R6] Code 1 is -100 dB, 255 is 27 dB
// [R7] Half dB per step, 202 is +0.5 dB
// [R8] Code 201, the reset value, is unity
// [R9] Gain trim at 0x49, reset 0x80, bits 7:4
// [R10] Trim runs -0.8 dB to +0.7 dB linearly
// [R11] Trim step 0.1 dB, 8 is unity
// [R12] Trim low nibble reads zero, ignores writes
// [R13] Channel 3 delay at 0x4A, reset zero
// [R14] Channel 2 delay at 0x45, reset zero
// [R15] Volume and trim multiply onto each sample
// [R16] Register changes never corrupt other channels
module cvg_chan_regs (
  input wire logic core_clk_i, // Device clock, 200 MHz
  input wire logic rst_n_i, // Async reset, active low
  input wire cvg_pkg::cvg_reg_req_t reg_req_i, // Control port access
  output logic [7:0] reg_rdata_o, // Read data, valid cycle after rd
  output logic reg_hit_o, // Read hit a mapped address
  input wire logic mod_tick_i, // Modulator clock cycle pulse
  input wire logic ch2_pdm_i, // Channel 2 modulator bit
  input wire logic ch3_pdm_i, // Channel 3 modulator bit
  output logic ch2_pdm_o, // Channel 2 delayed bit
  output logic ch3_pdm_o, // Channel 3 delayed bit
  input wire cvg_pkg::cvg_sample_t ch3_sample_i, // Decimated sample in
  output cvg_pkg::cvg_sample_t ch3_sample_o // Scaled sample out
);
  import cvg_pkg::*;

  logic [7:0] second_chan_delay_reg;
  logic [7:0] third_chan_volume_reg;
  logic [7:0] third_chan_gain_reg;
  logic [7:0] third_chan_delay_reg;

  wire logic [7:0] second_chan_delay_trim = second_chan_delay_reg;
  wire logic [7:0] third_chan_volume_code = third_chan_volume_reg;
  wire logic [3:0] third_chan_gain_trim =
    third_chan_gain_reg[CVG_TRIM_MSB:CVG_TRIM_LSB];
  wire logic [7:0] third_chan_delay_trim = third_chan_delay_reg;

  // Address decode
  wire logic sel_ch2_delay = reg_req_i.addr == CVG_CH2_DELAY_ADDR;
  wire logic sel_ch3_vol = reg_req_i.addr == CVG_CH3_VOL_ADDR;
  wire logic sel_ch3_gain = reg_req_i.addr == CVG_CH3_GAIN_ADDR;
  wire logic sel_ch3_delay = reg_req_i.addr == CVG_CH3_DELAY_ADDR;
  wire logic sel_any = sel_ch2_delay | sel_ch3_vol | sel_ch3_gain
    | sel_ch3_delay;

  // Reserved nibble is not stored, so it can only read back as zero
  wire logic [7:0] gain_wdata =
    {reg_req_i.wdata[CVG_TRIM_MSB:CVG_TRIM_LSB], 4'h0}; // [R12]

  logic [7:0] next_rdata;
  assign next_rdata =
    ({8{sel_ch2_delay}} & second_chan_delay_reg) |
    ({8{sel_ch3_vol}} & third_chan_volume_reg) |
    ({8{sel_ch3_gain}} & third_chan_gain_reg) |
    ({8{sel_ch3_delay}} & third_chan_delay_reg);

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      second_chan_delay_reg <= CVG_DELAY_RST; // [R3] [R14]
      third_chan_volume_reg <= CVG_VOL_RST; // [R4] [R8]
      third_chan_gain_reg <= CVG_GAIN_REG_RST; // [R9]
      third_chan_delay_reg <= CVG_DELAY_RST; // [R13]
    end else if (reg_req_i.wr) begin
      if (sel_ch2_delay) begin
        second_chan_delay_reg <= reg_req_i.wdata; // [R3] [R14]
      end
      if (sel_ch3_vol) begin
        third_chan_volume_reg <= reg_req_i.wdata; // [R4]
      end
      if (sel_ch3_gain) begin
        third_chan_gain_reg <= gain_wdata; // [R9] [R12]
      end
      if (sel_ch3_delay) begin
        third_chan_delay_reg <= reg_req_i.wdata; // [R13]
      end
    end
  end

  // Unmapped reads return zero with the hit flag low
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 8'h00;
      reg_hit_o <= 1'b0;
    end else if (reg_req_i.rd) begin
      reg_rdata_o <= next_rdata;
      reg_hit_o <= sel_any;
    end
  end

  // Each channel has its own delay line, so a new code for one channel
  // cannot disturb the other
  cvg_delay_line u_ch2_delay (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .mod_tick_i(mod_tick_i),
    .pdm_bit_i(ch2_pdm_i),
    .code_i(second_chan_delay_trim),
    .pdm_bit_o(ch2_pdm_o)
  ); // [R1] [R2] [R16]

  cvg_delay_line u_ch3_delay (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .mod_tick_i(mod_tick_i),
    .pdm_bit_i(ch3_pdm_i),
    .code_i(third_chan_delay_trim),
    .pdm_bit_o(ch3_pdm_o)
  ); // [R1] [R2] [R16]

  // Sample path: volume in stage one, trim in stage two
  localparam int P1_W = CVG_SAMPLE_W + CVG_VOL_GAIN_W + 1;
  localparam int P2_W = 32 + CVG_TRIM_GAIN_W + 1;
  localparam logic signed [31:0] SAT_MAX = 32'sh007f_ffff;
  localparam logic signed [31:0] SAT_MIN = -32'sh0080_0000;

  wire logic [CVG_VOL_GAIN_W-1:0] vol_lin =
    cvg_vol_gain(third_chan_volume_code); // [R5] [R6] [R7] [R8]
  wire logic [CVG_TRIM_GAIN_W-1:0] trim_lin =
    cvg_trim_gain(third_chan_gain_trim); // [R10] [R11]

  wire logic signed [P1_W-1:0] prod1 =
    P1_W'(ch3_sample_i.data) * $signed({1'b0, vol_lin}); // [R15]
  wire logic signed [P1_W-1:0] prod1_sh = prod1 >>> CVG_VOL_FRAC;

  logic s1_valid;
  logic signed [31:0] s1_data;
  logic [CVG_TRIM_GAIN_W-1:0] s1_trim;

  // Gains are captured with the sample, so a write mid-pipe cannot mix
  // the old and new setting on one sample
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_valid <= 1'b0;
      s1_data <= 32'sh0000_0000;
      s1_trim <= 17'h1_0000;
    end else begin
      s1_valid <= ch3_sample_i.valid;
      if (ch3_sample_i.valid) begin
        s1_data <= prod1_sh[31:0];
        s1_trim <= trim_lin; // [R16]
      end
    end
  end

  wire logic signed [P2_W-1:0] prod2 =
    P2_W'(s1_data) * $signed({1'b0, s1_trim}); // [R15]
  wire logic signed [P2_W-1:0] prod2_sh = prod2 >>> CVG_TRIM_FRAC;
  wire logic signed [31:0] p2_w = prod2_sh[31:0];
  wire logic [CVG_SAMPLE_W-1:0] sat_data =
    (p2_w > SAT_MAX) ? SAT_MAX[CVG_SAMPLE_W-1:0] :
    (p2_w < SAT_MIN) ? SAT_MIN[CVG_SAMPLE_W-1:0] :
    p2_w[CVG_SAMPLE_W-1:0];

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ch3_sample_o <= '0;
    end else begin
      ch3_sample_o.valid <= s1_valid;
      if (s1_valid) begin
        ch3_sample_o.data <= sat_data;
      end
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  vol_write_a: assert property ( // [R4]
    reg_req_i.wr && sel_ch3_vol |=> third_chan_volume_reg ==
      $past(reg_req_i.wdata))
    else $error("volume write not stored");

  gain_rsvd_a: assert property ( // [R12]
    reg_req_i.rd && sel_ch3_gain |=> reg_rdata_o[3:0] == 4'h0 && reg_hit_o)
    else $error("reserved trim bits read nonzero");

  gain_write_a: assert property ( // [R9]
    reg_req_i.wr && sel_ch3_gain ##1 reg_req_i.rd && sel_ch3_gain
      |=> reg_rdata_o[7:4] == $past(reg_req_i.wdata[7:4], 2))
    else $error("trim write did not read back");

  ch2_delay_rw_a: assert property ( // [R14]
    reg_req_i.wr && sel_ch2_delay ##1 reg_req_i.rd && sel_ch2_delay
      |=> reg_rdata_o == $past(reg_req_i.wdata, 2))
    else $error("channel 2 delay did not read back");

  ch3_delay_rw_a: assert property ( // [R13]
    reg_req_i.wr && sel_ch3_delay |=> third_chan_delay_reg ==
      $past(reg_req_i.wdata))
    else $error("channel 3 delay write not stored");

  mute_out_a: assert property ( // [R5]
    ch3_sample_i.valid && third_chan_volume_code == CVG_VOL_MUTE
      |-> ##2 ch3_sample_o.valid && ch3_sample_o.data == '0)
    else $error("muted channel produced a nonzero sample");

  unity_out_a: assert property ( // [R8]
    ch3_sample_i.valid && third_chan_volume_code == CVG_VOL_UNITY &&
      third_chan_gain_trim == CVG_TRIM_UNITY
      |-> ##2 ch3_sample_o.data == $past(ch3_sample_i.data, 2))
    else $error("unity setting changed the sample");

  half_db_a: assert property ( // [R7]
    ch3_sample_i.valid && third_chan_volume_code == 8'hca
      |=> s1_valid && $past(vol_lin) == 29'h010f_2c00)
    else $error("code 202 gain is not +0.5 dB");

  unmapped_a: assert property (
    reg_req_i.rd && !sel_any |=> reg_rdata_o == 8'h00 && !reg_hit_o)
    else $error("unmapped read returned data");

  ch2_delay_wr_a: assert property ( // [R3]
    reg_req_i.wr && sel_ch2_delay |=> second_chan_delay_reg ==
      $past(reg_req_i.wdata))
    else $error("channel 2 delay write not stored");

  rsvd_store_a: assert property ( // [R12]
    reg_req_i.wr && sel_ch3_gain |=> third_chan_gain_reg[3:0] == 4'h0 &&
      third_chan_gain_reg[7:4] == $past(reg_req_i.wdata[7:4]))
    else $error("trim register stored reserved bits");

  vol_hold_a: assert property ( // [R4]
    !(reg_req_i.wr && sel_ch3_vol) |=> $stable(third_chan_volume_reg))
    else $error("volume changed without a write");

  sample_lat_a: assert property ( // [R15]
    ch3_sample_i.valid |-> ##2 ch3_sample_o.valid)
    else $error("scaled sample not delivered two cycles later");

  trim_span_a: assert property ( // [R10]
    ch3_sample_i.valid && third_chan_gain_trim == 4'h0 |=>
      s1_trim == 17'h0_e97a)
    else $error("lowest trim code is not minus 0.8 dB");

  mute_c: cover property (ch3_sample_i.valid && third_chan_volume_code == 8'h00);
  max_vol_c: cover property (ch3_sample_i.valid && third_chan_volume_code == 8'hff);
  min_trim_c: cover property (ch3_sample_i.valid && third_chan_gain_trim == 4'h0);
  delay_c: cover property (mod_tick_i && third_chan_delay_trim == 8'hff);

endmodule // cvg_chan_regs
`default_nettype wire

// [channel_volume_gain_phase_regs_test.sv]
`timescale 1ns/1ps
`default_nettype none
module channel_volume_gain_phase_regs_test;
  import cvg_pkg::*;
  logic core_clk_i, rst_n_i, mod_tick_i, ch2_pdm_i, ch3_pdm_i;
  logic ch2_pdm_o, ch3_pdm_o, reg_hit_o;
  logic [7:0] reg_rdata_o;
  cvg_reg_req_t req;
  cvg_sample_t smp_in, smp_out;
  int err_total, checks_done;
  logic [7:0] addrs [4] = '{8'h45, 8'h48, 8'h49, 8'h4a};
  logic [7:0] rvals [4] = '{8'h00, 8'hc9, 8'h80, 8'h00};

  cvg_chan_regs dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .reg_req_i(req), .reg_rdata_o(reg_rdata_o), .reg_hit_o(reg_hit_o),
    .mod_tick_i(mod_tick_i), .ch2_pdm_i(ch2_pdm_i), .ch3_pdm_i(ch3_pdm_i),
    .ch2_pdm_o(ch2_pdm_o), .ch3_pdm_o(ch3_pdm_o),
    .ch3_sample_i(smp_in), .ch3_sample_o(smp_out));

  initial begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Tasks start and end 1 ns after a rising edge; wr leaves its strobe
  // up so back-to-back calls never drive it twice in one time step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge core_clk_i);
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] d,
      input logic h);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge core_clk_i);
    #1 req = '0;
    // Extra edge is harmless: read data stands until the next read
    @(posedge core_clk_i);
    #1 check({24'h0, reg_rdata_o}, {24'h0, d});
    check({31'h0, reg_hit_o}, {31'h0, h});
  endtask

  task automatic do_reset();
    req = '0;
    rst_n_i = 1'b0;
    repeat (16) @(posedge core_clk_i);
    #1 rst_n_i = 1'b1;
    for (int i = 0; i < 4; i++) begin
      rd(addrs[i], rvals[i], 1'b1);
    end
  endtask

  function automatic logic pat(input int k);
    return ((k * 37) % 11) > 4;
  endfunction

  // Both lines run at once; ch3 volume rewritten between ticks
  task automatic run_delay(input logic [7:0] c2, input logic [7:0] c3);
    logic h2 [300];
    logic h3 [300];
    wr(8'h45, c2);
    wr(8'h4a, c3);
    for (int k = 0; k < 300; k++) begin
      req = '0;
      h2[k] = pat(k);
      h3[k] = pat(k + 5);
      ch2_pdm_i = h2[k];
      ch3_pdm_i = h3[k];
      mod_tick_i = 1'b1;
      @(posedge core_clk_i);
      #1 mod_tick_i = 1'b0;
      // Flip inputs off tick so non-tick sampling shows up
      ch2_pdm_i = ~h2[k];
      ch3_pdm_i = ~h3[k];
      if (k >= 256) begin
        check({31'h0, ch2_pdm_o}, {31'h0, h2[k - c2]});
        check({31'h0, ch3_pdm_o}, {31'h0, h3[k - c3]});
      end
      wr(8'h48, k[7:0]);
    end
  endtask

  // Output valid stands for one cycle, right after the second edge
  task automatic sample(input logic signed [23:0] x,
      output logic signed [23:0] y);
    req = '0;
    smp_in.valid = 1'b1;
    smp_in.data = x;
    @(posedge core_clk_i);
    #1 smp_in.valid = 1'b0;
    smp_in.data = ~x;
    @(posedge core_clk_i);
    #1 check({31'h0, smp_out.valid}, 32'h1);
    y = smp_out.data;
  endtask

  task automatic set_gain(input logic [7:0] v, input logic [3:0] t);
    wr(8'h48, v);
    wr(8'h49, {t, 4'h0});
  endtask

  task automatic near(input logic signed [23:0] x, input int v,
      input int t, input real tol);
    real e, d;
    logic signed [23:0] y;
    set_gain(v[7:0], t[3:0]);
    e = $itor(x) * (10.0 ** (((v - 201) * 0.5 + (t - 8) * 0.1) / 20.0));
    sample(x, y);
    d = $itor(y) - e;
    if (d < 0.0) d = -d;
    check({31'h0, (d <= (e < 0.0 ? -e : e) * tol + 2.0)}, 32'h1);
  endtask

  initial begin
    logic signed [23:0] y;
    logic signed [63:0] p;
    logic [7:0] e8;
    err_total = 0;
    checks_done = 0;
    rst_n_i = 1'b0;
    mod_tick_i = 1'b0;
    ch2_pdm_i = 1'b0;
    ch3_pdm_i = 1'b0;
    req = '0;
    smp_in = '0;
    @(posedge core_clk_i);
    #1 do_reset();
    for (int i = 0; i < 4; i++) begin
      e8 = (i == 2) ? 8'ha0 : 8'ha5;
      wr(addrs[i], 8'ha5);
      rd(addrs[i], e8, 1'b1);
    end
    wr(8'h49, 8'h6f);
    rd(8'h49, 8'h60, 1'b1);
    wr(8'h47, 8'hff);
    rd(8'h47, 8'h00, 1'b0);
    rd(8'h48, 8'ha5, 1'b1);
    run_delay(8'd0, 8'd255);
    run_delay(8'd3, 8'd1);
    run_delay(8'd255, 8'd0);
    // Mid-run reset must restore every field
    do_reset();
    sample(24'h12_3456, y);
    check({8'h0, y}, 32'h0012_3456);
    sample(-24'sd5, y);
    check({8'h0, y}, 32'h00ff_fffb);
    set_gain(8'd0, 4'd8);
    sample(24'h7f_ffff, y);
    check({8'h0, y}, 32'h0000_0000);
    set_gain(8'd202, 4'd8);
    sample(24'h12_3457, y);
    p = (64'sh12_3457 * 64'sh010f_2c00) >>> 24;
    check({8'h0, y}, {8'h0, p[23:0]});
    for (int v = 180; v <= 230; v += 5) begin
      near(24'h08_0000, v, 8, 0.01);
    end
    near(24'h7f_ffff, 1, 8, 0.05);
    near(24'h01_0000, 255, 8, 0.05);
    for (int t = 0; t < 16; t++) begin
      near(24'h40_0000, 201, t, 0.003);
    end
    near(-24'sh30_0000, 203, 15, 0.01);
    set_gain(8'd255, 4'd8);
    sample(24'h10_0000, y);
    check({8'h0, y}, 32'h007f_ffff);
    sample(-24'sh10_0000, y);
    check({8'h0, y}, 32'h0080_0000);
    complete_run();
  end

  initial begin
    #200000;
    err_total++;
    complete_run();
  end
endmodule // channel_volume_gain_phase_regs_test
`default_nettype wire
